// >>> rtl/arith_pkg.sv
// shared constants and types for the arithmetic decode and execute block
// What this block does
// - fetch operand bytes per opcode length
// - one or two machine cycles, except multiply/divide
// - multiply and divide: one byte, four cycles
// - add decodes 2x, 25, 26/27, 24
// - add with carry decodes 3x, 35, 36/37, 34
// - subtract borrow decodes 9x, 95, 96/97, 94
// - increment decodes 04, 0x, 05, 06/07
// - decrement decodes 14, 1x, 15, 16/17
// - opcode A3 increments 16-bit pointer pair
// - indirect forms use selected pointer register
// - operand, second, status registers at E0/F0/D0, zero
// - pointer bytes at 83/82, reset zero
`default_nettype none
package arith_pkg;
    // ==================== register indices
    localparam logic [7:0] IDX_DPL     = 8'h82; // data_pointer_low
    localparam logic [7:0] IDX_DPH     = 8'h83; // data_pointer_high
    localparam logic [7:0] IDX_PSW     = 8'hD0; // program_status_word
    localparam logic [7:0] IDX_ACC     = 8'hE0; // main_operand_register
    localparam logic [7:0] IDX_B       = 8'hF0; // second_operand_register
    localparam logic [7:0] IDX_OPCODE  = 8'h00; // write starts execution
    localparam logic [7:0] IDX_OPERAND = 8'h01; // second instruction byte
    localparam logic [7:0] IDX_STATUS  = 8'h02; // busy, illegal, len, cycles
    localparam logic [2:0] IDX_RAM_HI  = 3'h2;  // ram window 0x40..0x5F
    localparam logic [7:0] RESET_BYTE  = 8'h00; // all five registers
    // ==================== status word bits
    localparam int PSW_CY = 7; // carry
    localparam int PSW_AC = 6; // auxiliary carry
    localparam int PSW_RS = 3; // bank select, two bits
    localparam int PSW_OV = 2; // overflow
    // ==================== special opcodes
    localparam logic [7:0] OP_INCDP = 8'hA3;
    localparam logic [7:0] OP_MUL   = 8'hA4;
    localparam logic [7:0] OP_DIV   = 8'h84;
    localparam logic [7:0] OP_DA    = 8'hD4;
    // ==================== timing
    localparam int          OSC_PER_MC = 12; // clocks per machine cycle
    localparam logic [5:0]  MC_CLKS    = 6'(OSC_PER_MC);
    // ==================== types
    typedef enum logic [3:0] {
        C_NONE = 4'h0, C_ADD = 4'h1, C_ADD_WITH_CARRY_OP = 4'h2, C_SUBTRACT_BORROW_OP = 4'h3,
        C_INC = 4'h4, C_DEC = 4'h5, C_INCDP = 4'h6, C_MUL = 4'h7,
        C_DIV = 4'h8, C_DA = 4'h9
    } op_cls_t;
    typedef enum logic [2:0] {
        S_NONE = 3'h0, S_ACC = 3'h1, S_REG = 3'h2, S_DIR = 3'h3,
        S_IND = 3'h4, S_IMM = 3'h5
    } src_t;
    typedef struct packed {
        op_cls_t    cls; // operation
        src_t       src; // operand form
        logic [1:0] len; // bytes
        logic [2:0] cyc; // machine cycles
    } decode_t;
    typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_EXEC = 1'b1} state_t;
endpackage : arith_pkg
`default_nettype wire

// >>> rtl/arith_instr_decode_exec.sv
// arithmetic instruction decode and execute unit with wishbone slave
`default_nettype none
module arith_instr_decode_exec (
    input  wire logic        clk_i,  // core clock, 100 MHz
    input  wire logic        rst_i,  // synchronous reset, high
    input  wire logic        cyc_i,  // wishbone cycle
    input  wire logic        stb_i,  // wishbone strobe
    input  wire logic        we_i,   // write enable
    input  wire logic [9:0]  adr_i,  // byte address
    input  wire logic [3:0]  sel_i,  // byte lanes
    input  wire logic [31:0] dat_i,  // write data
    output logic      [31:0] dat_o,  // read data
    output logic             ack_o   // one-cycle acknowledge
);
    import arith_pkg::*;

    // ==================== state
    logic [7:0]  acc_r, b_r, psw_r, dpl_r, dph_r;  // visible registers
    logic [7:0]  opc_r, opnd_r;                    // instruction bytes
    logic [7:0]  mem_r [32];                       // internal data bytes
    logic [5:0]  cnt_r;                            // clocks left
    state_t      st_r;                             // idle / executing
    decode_t     dec_r;                            // latched decode
    logic        ack_r, ill_r;                     // ack, illegal flag
    logic [31:0] dat_r;                            // read data

    // ==================== decode
    function automatic decode_t decode(input logic [7:0] op);
        decode_t d;
        d = '{cls: C_NONE, src: S_NONE, len: 2'd1, cyc: 3'd1};
        case (op[7:4])
            4'h0: d.cls = C_INC;
            4'h1: d.cls = C_DEC;
            4'h2: d.cls = C_ADD;
            4'h3: d.cls = C_ADD_WITH_CARRY_OP;
            4'h9: d.cls = C_SUBTRACT_BORROW_OP;
            default: d.cls = C_NONE;
        endcase
        if (d.cls != C_NONE) begin
            if (op[3]) d.src = S_REG;
            else if (op[3:1] == 3'h3) d.src = S_IND;
            else if (op[3:0] == 4'h5) d.src = S_DIR;
            else if (op[3:0] == 4'h4) d.src = (op[7:5] == 3'h0) ? S_ACC : S_IMM;
            else d.cls = C_NONE;
            if (d.src == S_DIR || d.src == S_IMM) d.len = 2'd2;
        end
        case (op)
            OP_INCDP: d = '{cls: C_INCDP, src: S_NONE, len: 2'd1, cyc: 3'd2};
            OP_MUL:   d = '{cls: C_MUL, src: S_NONE, len: 2'd1, cyc: 3'd4};
            OP_DIV:   d = '{cls: C_DIV, src: S_NONE, len: 2'd1, cyc: 3'd4};
            OP_DA:    d = '{cls: C_DA, src: S_NONE, len: 2'd1, cyc: 3'd1};
            default:  ;
        endcase
        return d;
    endfunction : decode

    // ==================== bus decode
    wire [7:0]  idx     = adr_i[9:2];                 // register index
    wire        req     = cyc_i && stb_i && !ack_r;   // new request
    wire        wr0     = req && we_i && sel_i[0];    // low lane write
    wire        is_ram  = (idx[7:5] == IDX_RAM_HI);   // ram window hit
    wire [7:0]  pswv    = {psw_r[7:1], ^acc_r};       // parity follows acc
    wire        commit  = (st_r == ST_EXEC) && (cnt_r == 6'h00);
    wire        start   = wr0 && (idx == IDX_OPCODE) && (st_r == ST_IDLE);
    wire decode_t dec_w = decode(dat_i[7:0]);

    // direct byte read: sfrs by address, low ram below 0x20
    function automatic logic [7:0] rd_dir(input logic [7:0] a,
                                          input logic [7:0] m);
        case (a)
            IDX_ACC: return acc_r;
            IDX_B:   return b_r;
            IDX_PSW: return pswv;
            IDX_DPL: return dpl_r;
            IDX_DPH: return dph_r;
            default: return (a[7:5] == 3'h0) ? m : 8'h00;
        endcase
    endfunction : rd_dir

    // ==================== operand fetch
    wire [4:0] reg_a = {psw_r[PSW_RS+1:PSW_RS], opc_r[2:0]};     // bank register
    wire [4:0] ptr_a = {psw_r[PSW_RS+1:PSW_RS], 2'b00, opc_r[0]};
    wire [7:0] ptr_v = mem_r[ptr_a];                              // pointer value
    wire [4:0] ind_a = ptr_v[4:0];
    wire [7:0] dir_v = rd_dir(opnd_r, mem_r[opnd_r[4:0]]);
    wire [7:0] sv    = (dec_r.src == S_REG) ? mem_r[reg_a] :
                       (dec_r.src == S_DIR) ? dir_v :
                       (dec_r.src == S_IND) ? mem_r[ind_a] :
                       (dec_r.src == S_IMM) ? opnd_r : acc_r;

    // ==================== arithmetic
    wire       cin   = (dec_r.cls == C_ADD) ? 1'b0 : psw_r[PSW_CY];
    wire [8:0] sum9  = {1'b0, acc_r} + {1'b0, sv} + {8'h00, cin};
    wire [4:0] sum5  = {1'b0, acc_r[3:0]} + {1'b0, sv[3:0]} + {4'h0, cin};
    wire [8:0] dif9  = {1'b0, acc_r} - {1'b0, sv} - {8'h00, cin};
    wire [4:0] dif5  = {1'b0, acc_r[3:0]} - {1'b0, sv[3:0]} - {4'h0, cin};
    wire       ov_a  = (acc_r[7] == sv[7]) && (sum9[7] != acc_r[7]);
    wire       ov_s  = (acc_r[7] != sv[7]) && (dif9[7] != acc_r[7]);
    wire [15:0] prod = acc_r * b_r;
    wire [7:0] quo   = (b_r == 8'h00) ? acc_r : acc_r / b_r;
    wire [7:0] rem   = (b_r == 8'h00) ? b_r : acc_r % b_r;
    wire [15:0] dp1  = {dph_r, dpl_r} + 16'h0001;
    // decimal adjust: low digit first, then high digit with its carry
    wire       da_lo = (acc_r[3:0] > 4'h9) || psw_r[PSW_AC];
    wire [8:0] da1   = {1'b0, acc_r} + (da_lo ? 9'h006 : 9'h000);
    wire       da_hi = (da1[7:4] > 4'h9) || da1[8] || psw_r[PSW_CY];
    wire [8:0] da2   = {1'b0, da1[7:0]} + (da_hi ? 9'h060 : 9'h000);

    // ==================== result select
    logic [7:0] acc_nxt, b_nxt, psw_nxt, loc_nxt;
    always_comb begin
        acc_nxt = acc_r;
        b_nxt   = b_r;
        psw_nxt = psw_r;
        loc_nxt = sv + 8'h01;
        case (dec_r.cls)
            C_ADD, C_ADD_WITH_CARRY_OP: begin
                acc_nxt = sum9[7:0];
                psw_nxt[PSW_CY] = sum9[8];
                psw_nxt[PSW_AC] = sum5[4];
                psw_nxt[PSW_OV] = ov_a;
            end
            C_SUBTRACT_BORROW_OP: begin
                acc_nxt = dif9[7:0];
                psw_nxt[PSW_CY] = dif9[8];
                psw_nxt[PSW_AC] = dif5[4];
                psw_nxt[PSW_OV] = ov_s;
            end
            C_DEC: loc_nxt = sv - 8'h01;
            C_MUL: begin
                acc_nxt = prod[7:0];
                b_nxt   = prod[15:8];
                psw_nxt[PSW_CY] = 1'b0;
                psw_nxt[PSW_OV] = (prod[15:8] != 8'h00);
            end
            C_DIV: begin
                acc_nxt = quo;
                b_nxt   = rem;
                psw_nxt[PSW_CY] = 1'b0;
                psw_nxt[PSW_OV] = (b_r == 8'h00);
            end
            C_DA: begin
                acc_nxt = da2[7:0];
                psw_nxt[PSW_CY] = psw_r[PSW_CY] | da1[8] | da2[8];
            end
            default: ;
        endcase
    end

    // inc/dec write back to the operand's own location
    wire incdec = (dec_r.cls == C_INC) || (dec_r.cls == C_DEC);
    wire [7:0] wloc = (dec_r.src == S_REG) ? {3'h0, reg_a} :
                      (dec_r.src == S_IND) ? {3'h0, ind_a} : opnd_r;
    wire wr_acc  = incdec && (dec_r.src == S_ACC || (dec_r.src == S_DIR && wloc == IDX_ACC));
    wire wr_sfr  = incdec && dec_r.src == S_DIR && wloc[7];       // sfr target
    wire wr_mem  = incdec && !wr_sfr && dec_r.src != S_ACC && wloc[7:5] == 3'h0;

    // ==================== sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r  <= ST_IDLE;
            cnt_r <= 6'h00;
        end else if (start) begin
            st_r  <= (dec_w.cls == C_NONE) ? ST_IDLE : ST_EXEC;
            cnt_r <= 6'(dec_w.cyc * MC_CLKS - 6'h01);
        end else if (commit) begin
            st_r  <= ST_IDLE;
        end else if (st_r == ST_EXEC) begin
            cnt_r <= cnt_r - 6'h01;
        end
    end

    // ==================== instruction bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opc_r  <= 8'h00;
            opnd_r <= 8'h00;
            dec_r  <= '{cls: C_NONE, src: S_NONE, len: 2'd1, cyc: 3'd1};
            ill_r  <= 1'b0;
        end else begin
            if (start) begin
                opc_r <= dat_i[7:0];
                dec_r <= dec_w;
                ill_r <= (dec_w.cls == C_NONE);
            end
            // operand byte is frozen while executing
            if (wr0 && idx == IDX_OPERAND && st_r == ST_IDLE) opnd_r <= dat_i[7:0];
        end
    end

    // ==================== registers; commit wins over a bus write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_r <= RESET_BYTE;
            b_r   <= RESET_BYTE;
            psw_r <= RESET_BYTE;
            dpl_r <= RESET_BYTE;
            dph_r <= RESET_BYTE;
        end else if (commit) begin
            acc_r <= wr_acc ? loc_nxt : acc_nxt;
            b_r   <= (wr_sfr && wloc == IDX_B) ? loc_nxt : b_nxt;
            psw_r <= (wr_sfr && wloc == IDX_PSW) ? loc_nxt : psw_nxt;
            if (dec_r.cls == C_INCDP) {dph_r, dpl_r} <= dp1;
            if (wr_sfr && wloc == IDX_DPL) dpl_r <= loc_nxt;
            if (wr_sfr && wloc == IDX_DPH) dph_r <= loc_nxt;
        end else if (wr0) begin
            if (idx == IDX_ACC) acc_r <= dat_i[7:0];
            if (idx == IDX_B)   b_r   <= dat_i[7:0];
            if (idx == IDX_PSW) psw_r <= dat_i[7:0];
            if (idx == IDX_DPL) dpl_r <= dat_i[7:0];
            if (idx == IDX_DPH) dph_r <= dat_i[7:0];
        end
    end

    // ==================== internal data memory, no reset
    always_ff @(posedge clk_i) begin
        if (commit && wr_mem) mem_r[wloc[4:0]] <= loc_nxt;
        else if (wr0 && is_ram) mem_r[idx[4:0]] <= dat_i[7:0];
    end

    // ==================== wishbone answer, one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            if (req) begin
                // unmapped indices answer with zero
                dat_r <= is_ram ? {24'h0, mem_r[idx[4:0]]} :
                         (idx == IDX_OPCODE)  ? {24'h0, opc_r} :
                         (idx == IDX_OPERAND) ? {24'h0, opnd_r} :
                         (idx == IDX_STATUS)  ? {24'h0, 1'b0, dec_r.cyc, dec_r.len, ill_r, st_r} :
                         (idx[7]) ? {24'h0, rd_dir(idx, 8'h00)} : 32'h0000_0000;
            end
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;

    // ==================== checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_start_long;
        start && (dec_w.cls == C_MUL || dec_w.cls == C_DIV);
    endsequence

    a_long_four_mc: assert property (s_start_long |-> ##48 commit)
        else $error("multiply/divide not four machine cycles");
    a_short_one_mc: assert property (start && dec_w.cyc == 3'd1 && dec_w.cls != C_NONE
        |=> !commit [*8] ##4 commit)
        else $error("one-cycle op not done in twelve clocks");
    a_incdp_carry: assert property (commit && dec_r.cls == C_INCDP
        |=> {dph_r, dpl_r} == $past(dp1))
        else $error("pointer pair increment wrong");
    a_add_sum: assert property (commit && dec_r.cls == C_ADD
        |=> acc_r == $past(acc_r) + $past(sv))
        else $error("add result wrong");
    a_subtract_borrow_op_borrow: assert property (commit && dec_r.cls == C_SUBTRACT_BORROW_OP
        |=> psw_r[PSW_CY] == ({1'b0, $past(acc_r)} < {1'b0, $past(sv)} + {8'h00, $past(psw_r[PSW_CY])}))
        else $error("borrow flag wrong");
    a_inc_acc: assert property (commit && opc_r == 8'h04
        |=> acc_r == $past(acc_r) + 8'h01)
        else $error("accumulator increment wrong");
    // reset itself is the trigger here, so the default disable must not apply
    a_reset_zero: assert property (disable iff (1'b0) rst_i |=> acc_r == 8'h00 && b_r == 8'h00 && psw_r == 8'h00 && dpl_r == 8'h00 && dph_r == 8'h00)
        else $error("registers not zero after reset");
    a_len_imm: assert property (start && dat_i[7:0] == 8'h24 |=> dec_r.len == 2'd2)
        else $error("immediate add length wrong");
    a_ack_pulse: assert property (ack_r |=> !ack_r)
        else $error("ack held over two cycles");
endmodule : arith_instr_decode_exec
`default_nettype wire

// >>> verif/arith_instr_decode_exec_tb.sv
// self-checking bench for the arithmetic decode and execute unit
`default_nettype none
// ==================== compare helper
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module arith_instr_decode_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import arith_pkg::*;
    // ==================== stimulus and observation signals
    logic        clk_i;      // core clock
    logic        rst_i;      // synchronous reset
    logic        cyc_i;      // bus cycle
    logic        stb_i;      // bus strobe
    logic        we_i;       // write enable
    logic [9:0]  adr_i;      // byte address
    logic [3:0]  sel_i;      // byte lanes
    logic [31:0] dat_i;      // write data
    logic [31:0] dat_o;      // read data
    logic        ack_o;      // acknowledge
    int          num_errors; // mismatches seen
    int          n_checks;   // comparisons made
    logic [7:0]  rv;         // scratch read value
    logic [7:0]  sfr [5];    // the five documented registers
    arith_instr_decode_exec uut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o)
    );
    // ==================== clock, 10 ns period
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // ==================== verdict and end of run
    task give_verdict;
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    // ==================== one classic bus cycle, held until ack
    task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h0, wd};
        sel_i <= 4'h1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++; // a missing ack counts as a failure
        end
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i); // bus idles one cycle between requests
    endtask : xfer
    task wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        xfer(1'b1, idx, wd, d);
    endtask : wr
    // ==================== run one instruction and check its outcome
    // status is sampled at the commit edge (still busy) and three edges later
    task ex(input logic [7:0] op, opnd, acc0, psw0, b0, accx, pswx, ci, cv);
        logic [1:0] ln;
        logic [2:0] cy;
        ln = (op inside {8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95, 8'h05, 8'h15}) ? 2'd2 : 2'd1;
        cy = (op == OP_INCDP) ? 3'd2 : ((op == OP_MUL || op == OP_DIV) ? 3'd4 : 3'd1);
        wr(IDX_ACC, acc0);
        wr(IDX_PSW, psw0);
        wr(IDX_B, b0);
        if (ln == 2'd2) begin
            wr(IDX_OPERAND, opnd); // operand byte goes first
        end
        wr(IDX_OPCODE, op);
        repeat (12 * cy - 3) @(posedge clk_i);
        xfer(1'b0, IDX_STATUS, 8'h00, rv);
        `CHK("status", {1'b0, cy, ln, 2'b01}, rv & 8'h7F)
        xfer(1'b0, IDX_STATUS, 8'h00, rv);
        `CHK("busy", 1'b0, rv[0])
        xfer(1'b0, IDX_ACC, 8'h00, rv);
        `CHK("acc", accx, rv)
        xfer(1'b0, IDX_PSW, 8'h00, rv);
        `CHK("psw", {pswx[7:1], ^accx}, rv)
        xfer(1'b0, ci, 8'h00, rv);
        `CHK("target", cv, rv)
    endtask : ex
    // ==================== watchdog, far beyond the roughly 1100 cycles needed
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        give_verdict();
    end
    // ==================== main sequence
    initial begin
        num_errors = 0;
        n_checks = 0;
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 10'h000;
        sel_i = 4'h0;
        dat_i = 32'h0;
        sfr = '{IDX_DPL, IDX_DPH, IDX_PSW, IDX_ACC, IDX_B};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (sfr[i]) begin
            xfer(1'b0, sfr[i], 8'h00, rv);
            `CHK("reset value", RESET_BYTE, rv)
        end
        // bank 0 registers and pointed-to bytes
        wr(8'h40, 8'h10);
        wr(8'h41, 8'h11);
        wr(8'h42, 8'h05);
        wr(8'h50, 8'h22);
        wr(8'h51, 8'h80);
        wr(8'h5F, 8'h7F);
        //  op     opnd   acc0   psw0   b0     accx   pswx   check  value
        ex(8'h24, 8'h7F, 8'h01, 8'h00, 8'h00, 8'h80, 8'h44, IDX_B, 8'h00);
        ex(8'h2A, 8'h00, 8'hFE, 8'h00, 8'h00, 8'h03, 8'hC0, IDX_B, 8'h00);
        ex(8'h25, 8'h1F, 8'h81, 8'h00, 8'h00, 8'h00, 8'hC0, IDX_B, 8'h00);
        ex(8'h26, 8'h00, 8'h11, 8'h00, 8'h00, 8'h33, 8'h00, IDX_B, 8'h00);
        ex(8'h27, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h84, IDX_B, 8'h00);
        ex(8'h34, 8'h01, 8'h0E, 8'h80, 8'h00, 8'h10, 8'h40, IDX_B, 8'h00);
        ex(8'h35, 8'h1F, 8'h00, 8'h80, 8'h00, 8'h80, 8'h44, IDX_B, 8'h00);
        ex(8'h3A, 8'h00, 8'hFA, 8'h80, 8'h00, 8'h00, 8'hC0, IDX_B, 8'h00);
        ex(8'h36, 8'h00, 8'h00, 8'h00, 8'h00, 8'h22, 8'h00, IDX_B, 8'h00);
        ex(8'h94, 8'h01, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hC0, IDX_B, 8'h00);
        ex(8'h95, 8'h1F, 8'h80, 8'h80, 8'h00, 8'h00, 8'h44, IDX_B, 8'h00);
        ex(8'h9A, 8'h00, 8'h10, 8'h00, 8'h00, 8'h0B, 8'h40, IDX_B, 8'h00);
        ex(8'h96, 8'h00, 8'h22, 8'h80, 8'h00, 8'hFF, 8'hC0, IDX_B, 8'h00);
        ex(8'h04, 8'h00, 8'hFF, 8'h80, 8'h00, 8'h00, 8'h80, IDX_B, 8'h00);
        ex(8'h14, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, IDX_B, 8'h00);
        ex(8'h05, 8'h1F, 8'h03, 8'h00, 8'h00, 8'h03, 8'h00, 8'h5F, 8'h80);
        ex(8'h0A, 8'h00, 8'h03, 8'h00, 8'h00, 8'h03, 8'h00, 8'h42, 8'h06);
        ex(8'h06, 8'h00, 8'h03, 8'h00, 8'h00, 8'h03, 8'h00, 8'h50, 8'h23);
        ex(8'h15, 8'h1F, 8'h03, 8'h00, 8'h00, 8'h03, 8'h00, 8'h5F, 8'h7F);
        ex(8'h1A, 8'h00, 8'h03, 8'h00, 8'h00, 8'h03, 8'h00, 8'h42, 8'h05);
        ex(8'h17, 8'h00, 8'h03, 8'h00, 8'h00, 8'h03, 8'h00, 8'h51, 8'h7F);
        ex(8'hD4, 8'h00, 8'hBD, 8'h00, 8'h00, 8'h23, 8'h80, IDX_B, 8'h00);
        ex(8'hA4, 8'h00, 8'h50, 8'h80, 8'hA0, 8'h00, 8'h04, IDX_B, 8'h32);
        ex(8'h84, 8'h00, 8'hFB, 8'h80, 8'h12, 8'h0D, 8'h00, IDX_B, 8'h11);
        ex(8'h84, 8'h00, 8'h42, 8'h80, 8'h00, 8'h42, 8'h04, IDX_B, 8'h00);
        // carry ripples from the low pointer byte into the high one
        wr(IDX_DPL, 8'hFF);
        wr(IDX_DPH, 8'h12);
        ex(8'hA3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, IDX_DPH, 8'h13);
        xfer(1'b0, IDX_DPL, 8'h00, rv);
        `CHK("dpl", 8'h00, rv)
        // a logic opcode is outside this group: flagged, never started
        wr(IDX_OPCODE, 8'h54);
        xfer(1'b0, IDX_STATUS, 8'h00, rv);
        `CHK("illegal", 2'b10, rv[1:0])
        // unmapped index reads zero and ignores writes
        wr(8'h30, 8'hAA);
        xfer(1'b0, 8'h30, 8'h00, rv);
        `CHK("unmapped", 8'h00, rv)
        give_verdict();
    end
endmodule : arith_instr_decode_exec_tb
`default_nettype wire
